// ---- rtl/io_port_pkg.sv ----
// Purpose: Constants for the eight-bit high-current I/O port.
// Assumes: AHB-Lite register access, 32-bit data, one register per word.
// Notes:   Printed offsets include a non-multiple of four, so they are indices.
// Contract
// - Eight pins, each output, input or peripheral
// - General output pin driven from latch bit
// - Reset: latch all ones, selects all zero
// - Drive-type bit picks open-drain or push-pull
// - Pull-up bit connects internal pull-up
// - Latch read returns stored latch values
// - Pin-state read returns live pin levels
// - Programming mode: bit1 boot/receive, bit0 transmit
// - Unlatched input sampling; outputs change after write
package io_port_pkg;

  // ---------------------------------------------------------------------
  // Register indices and byte addresses
  // ---------------------------------------------------------------------
  localparam logic [7:0]  IDX_LATCH   = 8'h00;
  localparam logic [7:0]  IDX_PULLUP  = 8'h04;
  localparam logic [7:0]  IDX_DRIVE   = 8'h0b;
  localparam logic [7:0]  IDX_PIN     = 8'h0c;
  localparam int          ADDR_BITS   = 10;
  localparam logic [9:0]  ADDR_LATCH  = {IDX_LATCH, 2'b00};
  localparam logic [9:0]  ADDR_PULLUP = {IDX_PULLUP, 2'b00};
  localparam logic [9:0]  ADDR_DRIVE  = {IDX_DRIVE, 2'b00};
  localparam logic [9:0]  ADDR_PIN    = {IDX_PIN, 2'b00};

  // ---------------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------------
  localparam int          PORT_W       = 8;
  localparam logic [7:0]  RST_LATCH    = 8'hff;
  localparam logic [7:0]  RST_PULLUP   = 8'h00;
  localparam logic [7:0]  RST_DRIVE    = 8'h00;
  localparam int          BIT_TX       = 0;
  localparam int          BIT_RX       = 1;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0]  HSIZE_WORD   = 3'b010;

endpackage : io_port_pkg

// ---- rtl/io_pin_cell.sv ----
// Purpose: One port pin's output selection and drive enables.
// Assumes: Open-drain low drive is modelled as enable active low with data 0.
// Notes:   Enable is active low while the cell drives the pin.
`timescale 1ns/1ps
`default_nettype none
module io_pin_cell (
  input  wire logic latch_i,     // Output latch bit
  input  wire logic periph_en_i, // Peripheral owns output
  input  wire logic periph_i,    // Peripheral output value
  input  wire logic push_pull_i, // Drive-type select bit
  input  wire logic pullup_i,    // Pull-up select bit
  output logic      out_o,       // Value towards the pin
  output logic      oe_n_o,      // Low while driving
  output logic      pullup_o     // Pull-up enable
);

  logic value;

  // Peripheral output is gated by latch so a zero latch forces low
  assign value  = periph_en_i ? (latch_i & periph_i) : latch_i;
  assign out_o  = value;
  // Push-pull drives both levels; open-drain only sinks a zero
  assign oe_n_o = ~(push_pull_i | ~value);
  assign pullup_o = pullup_i;

endmodule : io_pin_cell
`default_nettype wire

// ---- rtl/io_port.sv ----
// Purpose: Eight-bit high-current I/O port with AHB-Lite register access.
// Assumes: Pin inputs synchronous to REF_CLK_I; single-word transfers only.
// Notes:   Zero-wait-state slave; unmapped addresses read zero, writes dropped.
//          Read data is registered at the address-phase edge, so the pin
//          state seen by software is one cycle older than the data phase.
`timescale 1ns/1ps
`default_nettype none
module io_port (
  input  wire logic        REF_CLK_I,    // 25 MHz system clock
  input  wire logic        RST_I,        // Async reset, active high
  input  wire logic        HSEL_I,       // Slave select
  input  wire logic [31:0] HADDR_I,      // Byte address
  input  wire logic [1:0]  HTRANS_I,     // Transfer type
  input  wire logic        HWRITE_I,     // Write not read
  input  wire logic [2:0]  HSIZE_I,      // Transfer size
  input  wire logic        HREADY_I,     // Bus ready
  input  wire logic [31:0] HWDATA_I,     // Write data
  output logic      [31:0] HRDATA_O,     // Read data
  output logic             HREADYOUT_O,  // Slave ready
  output logic             HRESP_O,      // Always OKAY
  input  wire logic [7:0]  PIN_I,        // Pin levels
  output logic      [7:0]  PIN_O,        // Pin output values
  output logic      [7:0]  PIN_OE_N_O,   // Low while driving
  output logic      [7:0]  PULLUP_EN_O,  // Pull-up enables
  input  wire logic [7:0]  PERIPH_EN_I,  // Peripheral owns output
  input  wire logic [7:0]  PERIPH_OUT_I, // Peripheral output values
  output logic      [7:0]  PERIPH_IN_O,  // Pin levels to peripherals
  input  wire logic        PROG_MODE_I,  // Serial programming mode
  input  wire logic        UART_TX_I,    // Transmit in programming mode
  output logic             BOOT_RX_O     // Boot select and receive
);

  // -----------------------------------------------------------------------
  // Register state
  // -----------------------------------------------------------------------
  logic [7:0]  port_output_latch;
  logic [7:0]  port_pullup_select;
  logic [7:0]  port_drive_type_select;
  logic        wr_pend;
  logic        rd_pend;
  logic [9:0]  wr_addr;
  logic [9:0]  rd_addr;
  logic        addr_ok;
  logic [7:0]  eff_en;
  logic [7:0]  eff_out;
  logic [7:0]  out_pins;
  logic [7:0]  oe_n_pins;
  logic [7:0]  pu_pins;
  logic        access;
  logic [31:0] next_rdata;

  // Decode a word address onto one of the mapped registers
  function automatic logic mapped(input logic [9:0] a);
    mapped = (a == io_port_pkg::ADDR_LATCH) || (a == io_port_pkg::ADDR_PULLUP) ||
             (a == io_port_pkg::ADDR_DRIVE) || (a == io_port_pkg::ADDR_PIN);
  endfunction : mapped

  // -----------------------------------------------------------------------
  // Bus address phase
  // -----------------------------------------------------------------------
  // Valid single access; sizes other than word still take the low byte
  assign access  = HSEL_I && HREADY_I && (HTRANS_I == io_port_pkg::HTRANS_NONSEQ);
  assign addr_ok = mapped(HADDR_I[9:0]) && (HADDR_I[31:10] == 22'h00_0000);
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;

  // Hold write address for the data phase
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      wr_pend <= 1'b0;
      wr_addr <= 10'h000;
    end else begin
      wr_pend <= access && HWRITE_I && addr_ok;
      wr_addr <= HADDR_I[9:0];
    end
  end

  // Latch and select registers take data in the write data phase
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      port_output_latch      <= io_port_pkg::RST_LATCH;
      port_pullup_select     <= io_port_pkg::RST_PULLUP;
      port_drive_type_select <= io_port_pkg::RST_DRIVE;
    end else if (wr_pend) begin
      // Pins follow the new value from the edge ending the data phase
      case (wr_addr)
        io_port_pkg::ADDR_LATCH:  port_output_latch      <= HWDATA_I[7:0];
        io_port_pkg::ADDR_PULLUP: port_pullup_select     <= HWDATA_I[7:0];
        io_port_pkg::ADDR_DRIVE:  port_drive_type_select <= HWDATA_I[7:0];
        default: ;
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // Read path
  // -----------------------------------------------------------------------
  // Pins sampled in the address phase, no input latch behind them
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (HADDR_I[9:0])
      io_port_pkg::ADDR_LATCH:  next_rdata[7:0] = port_output_latch;
      io_port_pkg::ADDR_PULLUP: next_rdata[7:0] = port_pullup_select;
      io_port_pkg::ADDR_DRIVE:  next_rdata[7:0] = port_drive_type_select;
      io_port_pkg::ADDR_PIN:    next_rdata[7:0] = PIN_I;
      default:                  next_rdata = 32'h0000_0000;
    endcase
    if (!addr_ok) begin
      next_rdata = 32'h0000_0000;
    end
  end

  // Read data registered so it stands through the data phase
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      HRDATA_O <= 32'h0000_0000;
      rd_pend  <= 1'b0;
      rd_addr  <= 10'h000;
    end else begin
      rd_pend <= access && !HWRITE_I;
      rd_addr <= HADDR_I[9:0];
      if (access && !HWRITE_I) begin
        HRDATA_O <= next_rdata;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Pin muxing
  // -----------------------------------------------------------------------
  // Programming mode hands bit 0 to transmit, bit 1 back to the port latch
  always_comb begin
    eff_en  = PERIPH_EN_I;
    eff_out = PERIPH_OUT_I;
    if (PROG_MODE_I) begin
      eff_en[io_port_pkg::BIT_TX]  = 1'b1;
      eff_out[io_port_pkg::BIT_TX] = UART_TX_I;
      eff_en[io_port_pkg::BIT_RX]  = 1'b0;
    end
  end

  // One cell per pin
  genvar g;
  generate
    for (g = 0; g < io_port_pkg::PORT_W; g++) begin : g_pin
      io_pin_cell u_cell (
        .latch_i     (port_output_latch[g]),
        .periph_en_i (eff_en[g]),
        .periph_i    (eff_out[g]),
        .push_pull_i (port_drive_type_select[g]),
        .pullup_i    (port_pullup_select[g]),
        .out_o       (out_pins[g]),
        .oe_n_o      (oe_n_pins[g]),
        .pullup_o    (pu_pins[g])
      );
    end
  endgenerate

  // Input path to peripherals is the live pin level
  assign PIN_O       = out_pins;
  assign PIN_OE_N_O  = oe_n_pins;
  assign PULLUP_EN_O = pu_pins;
  assign PERIPH_IN_O = PIN_I;
  assign BOOT_RX_O   = PIN_I[io_port_pkg::BIT_RX];

  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  property p_reset_vals;
    @(posedge REF_CLK_I) $fell(RST_I) |->
      port_output_latch == io_port_pkg::RST_LATCH &&
      port_pullup_select == io_port_pkg::RST_PULLUP &&
      port_drive_type_select == io_port_pkg::RST_DRIVE;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

  property p_latch_write;
    @(posedge REF_CLK_I) disable iff (RST_I)
      access && HWRITE_I && HADDR_I[9:0] == io_port_pkg::ADDR_LATCH ##1 1'b1 |=>
      port_output_latch == $past(HWDATA_I[7:0]);
  endproperty
  a_latch_write: assert property (p_latch_write) else $error("latch not written");

  property p_gpio_out;
    @(posedge REF_CLK_I) disable iff (RST_I)
      !eff_en[2] |-> PIN_O[2] == port_output_latch[2];
  endproperty
  a_gpio_out: assert property (p_gpio_out) else $error("pin not from latch");

  property p_open_drain;
    @(posedge REF_CLK_I) disable iff (RST_I)
      !port_drive_type_select[3] && PIN_O[3] |-> PIN_OE_N_O[3];
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain drove high");

  property p_push_pull;
    @(posedge REF_CLK_I) disable iff (RST_I)
      port_drive_type_select[4] |-> !PIN_OE_N_O[4];
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("push-pull not driving");

  property p_pullup;
    @(posedge REF_CLK_I) disable iff (RST_I)
      PULLUP_EN_O == port_pullup_select;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up mismatch");

  property p_latch_read;
    @(posedge REF_CLK_I) disable iff (RST_I)
      access && !HWRITE_I && HADDR_I[9:0] == io_port_pkg::ADDR_LATCH |=>
      HRDATA_O == {24'h00_0000, $past(port_output_latch)};
  endproperty
  a_latch_read: assert property (p_latch_read) else $error("latch read wrong");

  property p_pin_read;
    @(posedge REF_CLK_I) disable iff (RST_I)
      access && !HWRITE_I && HADDR_I[9:0] == io_port_pkg::ADDR_PIN |=>
      HRDATA_O[7:0] == $past(PIN_I);
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("pin read wrong");

  property p_prog_tx;
    @(posedge REF_CLK_I) disable iff (RST_I)
      PROG_MODE_I |-> PIN_O[0] == (port_output_latch[0] & UART_TX_I);
  endproperty
  a_prog_tx: assert property (p_prog_tx) else $error("transmit not on bit 0");

  property p_periph_and;
    @(posedge REF_CLK_I) disable iff (RST_I)
      PERIPH_EN_I[5] && !port_output_latch[5] |-> !PIN_O[5];
  endproperty
  a_periph_and: assert property (p_periph_and) else $error("latch zero not forcing low");

  // -----------------------------------------------------------------------
  // Register bus checks
  // -----------------------------------------------------------------------
  // Pull-up and drive selects land at the end of their data phase
  property p_pullup_write;
    @(posedge REF_CLK_I) disable iff (RST_I)
      access && HWRITE_I && addr_ok && HADDR_I[9:0] == io_port_pkg::ADDR_PULLUP
      ##1 1'b1 |=> port_pullup_select == $past(HWDATA_I[7:0]);
  endproperty
  a_pullup_write: assert property (p_pullup_write) else $error("pull-up write lost");

  property p_drive_write;
    @(posedge REF_CLK_I) disable iff (RST_I)
      access && HWRITE_I && addr_ok && HADDR_I[9:0] == io_port_pkg::ADDR_DRIVE
      ##1 1'b1 |=> port_drive_type_select == $past(HWDATA_I[7:0]);
  endproperty
  a_drive_write: assert property (p_drive_write) else $error("drive write lost");

  // Select registers read back as stored
  property p_pullup_read;
    @(posedge REF_CLK_I) disable iff (RST_I)
      access && !HWRITE_I && addr_ok && HADDR_I[9:0] == io_port_pkg::ADDR_PULLUP |=>
      HRDATA_O == {24'h00_0000, $past(port_pullup_select)};
  endproperty
  a_pullup_read: assert property (p_pullup_read) else $error("pull-up read wrong");

  property p_drive_read;
    @(posedge REF_CLK_I) disable iff (RST_I)
      access && !HWRITE_I && addr_ok && HADDR_I[9:0] == io_port_pkg::ADDR_DRIVE |=>
      HRDATA_O == {24'h00_0000, $past(port_drive_type_select)};
  endproperty
  a_drive_read: assert property (p_drive_read) else $error("drive read wrong");

  // Unmapped reads answer zero in their data phase
  property p_unmapped_read;
    @(posedge REF_CLK_I) disable iff (RST_I)
      rd_pend && !mapped(rd_addr) |-> HRDATA_O == 32'h0000_0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  // Writes to the pin state or to no register change nothing
  property p_dropped_write;
    @(posedge REF_CLK_I) disable iff (RST_I)
      access && HWRITE_I && (!addr_ok || HADDR_I[9:0] == io_port_pkg::ADDR_PIN) |=> ##1
      $stable(port_output_latch) && $stable(port_pullup_select) &&
      $stable(port_drive_type_select);
  endproperty
  a_dropped_write: assert property (p_dropped_write) else $error("dropped write landed");

  // Registers move only at the edge that ends a write data phase
  property p_regs_hold;
    @(posedge REF_CLK_I) disable iff (RST_I)
      !wr_pend |=> $stable(port_output_latch) && $stable(port_pullup_select) &&
      $stable(port_drive_type_select);
  endproperty
  a_regs_hold: assert property (p_regs_hold) else $error("register moved without write");

  // Read data stands until the next read address phase
  property p_rdata_hold;
    @(posedge REF_CLK_I) disable iff (RST_I)
      !(access && !HWRITE_I) |=> $stable(HRDATA_O);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data did not stand");

  // Pins take a new latch value at the edge ending the write data phase
  property p_latch_to_pin;
    @(posedge REF_CLK_I) disable iff (RST_I)
      wr_pend && wr_addr == io_port_pkg::ADDR_LATCH |=>
      eff_en[2] || PIN_O[2] == $past(HWDATA_I[2]);
  endproperty
  a_latch_to_pin: assert property (p_latch_to_pin) else $error("pin missed latch write");

  // Bit one stays a port-driven input path in programming mode
  property p_prog_rx;
    @(posedge REF_CLK_I) disable iff (RST_I)
      PROG_MODE_I |-> BOOT_RX_O == PIN_I[io_port_pkg::BIT_RX] &&
      PIN_O[io_port_pkg::BIT_RX] == port_output_latch[io_port_pkg::BIT_RX];
  endproperty
  a_prog_rx: assert property (p_prog_rx) else $error("receive bit not an input");

  // Receive pin is released once software set it up as an input
  property p_prog_rx_free;
    @(posedge REF_CLK_I) disable iff (RST_I)
      PROG_MODE_I && port_output_latch[io_port_pkg::BIT_RX] &&
      !port_drive_type_select[io_port_pkg::BIT_RX] |-> PIN_OE_N_O[io_port_pkg::BIT_RX];
  endproperty
  a_prog_rx_free: assert property (p_prog_rx_free) else $error("receive pin driven");

  // -----------------------------------------------------------------------
  // Per-pin checks
  // -----------------------------------------------------------------------
  // Every pin, not just one sample bit, keeps the drive and gating rules
  generate
    for (g = 0; g < io_port_pkg::PORT_W; g++) begin : g_pin_chk
      // Released only when open-drain and the value is high
      property p_pin_release;
        @(posedge REF_CLK_I) disable iff (RST_I)
          PIN_OE_N_O[g] == (!port_drive_type_select[g] && PIN_O[g]);
      endproperty
      a_pin_release: assert property (p_pin_release) else $error("drive enable wrong");
      // Port function pins follow the latch bit
      property p_pin_latch;
        @(posedge REF_CLK_I) disable iff (RST_I)
          !eff_en[g] |-> PIN_O[g] == port_output_latch[g];
      endproperty
      a_pin_latch: assert property (p_pin_latch) else $error("pin not from latch bit");
      // Peripheral pins see latch AND peripheral value
      property p_pin_gate;
        @(posedge REF_CLK_I) disable iff (RST_I)
          eff_en[g] |-> PIN_O[g] == (port_output_latch[g] && eff_out[g]);
      endproperty
      a_pin_gate: assert property (p_pin_gate) else $error("peripheral pin not gated");
    end
  endgenerate

endmodule : io_port
`default_nettype wire

// ---- verification/pin_partner.sv ----
// Purpose: Far-side circuitry on the eight port pins.
// Assumes: One resolved level per pin, settled within a cycle.
// Notes:   Floating pins toggle so no level is settled by luck.
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  input  wire logic       clk_i,    // Bench clock
  input  wire logic [7:0] drv_i,    // Port drive values
  input  wire logic [7:0] oe_n_i,   // Low while port drives
  input  wire logic [7:0] pull_i,   // Pull-up enables
  input  wire logic [7:0] ext_en_i, // External driver on
  input  wire logic [7:0] ext_i,    // External levels
  output logic      [7:0] pin_o     // Resolved levels
);
  logic [7:0] junk = 8'h5a;
  // Floating pattern, changes every cycle
  always_ff @(posedge clk_i) junk <= ~junk;
  // Port drive wins, then external driver, then pull-up
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      if (!oe_n_i[b]) pin_o[b] = drv_i[b];
      else if (ext_en_i[b]) pin_o[b] = ext_i[b];
      else if (pull_i[b]) pin_o[b] = 1'b1;
      else pin_o[b] = junk[b];
    end
  end
endmodule : pin_partner
`default_nettype wire

// ---- verification/eight_bit_io_port_high_current_tb_top.sv ----
// Purpose: Self-checking bench for the I/O port.
// Assumes: Zero-wait AHB-Lite slave, registers at four times index.
// Notes:   Reads are checked from a queue by a bus monitor.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module eight_bit_io_port_high_current_tb_top;
  logic        clk = 0, rst = 1, hsel = 0, hwrite = 0, prog = 0, tx = 0, rd_dp = 0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, st = 32'h0000_cc87;
  logic        hready, hresp, boot;
  logic [7:0]  pin_w, pin_o, oe_n, pull, pin_in, p_en = 8'h00, p_out = 8'h00;
  logic [7:0]  ext_en = 8'h00, ext = 8'h00, la, dr, pu, eoe, mv, po;
  logic [7:0]  q[$];
  int          n_fail = 0, tests_run = 0;
  io_port io_port_inst (.REF_CLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(io_port_pkg::HSIZE_WORD),
    .HREADY_I(hready), .HWDATA_I(hwdata), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
    .HRESP_O(hresp), .PIN_I(pin_w), .PIN_O(pin_o), .PIN_OE_N_O(oe_n), .PULLUP_EN_O(pull),
    .PERIPH_EN_I(p_en), .PERIPH_OUT_I(p_out), .PERIPH_IN_O(pin_in), .PROG_MODE_I(prog),
    .UART_TX_I(tx), .BOOT_RX_O(boot));
  pin_partner pin_partner_inst (.clk_i(clk), .drv_i(pin_o), .oe_n_i(oe_n), .pull_i(pull),
    .ext_en_i(ext_en), .ext_i(ext), .pin_o(pin_w));
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  initial forever #20 clk = ~clk;
  function automatic logic [7:0] rnd();
    repeat (8) st = {st[30:0], st[31] ^ st[21] ^ st[1] ^ st[0]};
    return st[7:0];
  endfunction : rnd
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  // Bounded wait for hready at a rising edge
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    if (hready !== 1'b1) begin
      n_fail++;
      report_and_stop();
    end
  endtask : wait_rdy
  // One single word transfer; reads note their expectation first
  task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d,
                     input logic [7:0] ex);
    hsel <= 1'b1;
    htrans <= io_port_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {22'h0, a};
    if (!wr) q.push_back(ex);
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy();
  endtask : bus
  // Pin-side outputs, looked at once settled
  task automatic pins(input logic [7:0] eo, input logic [7:0] eo_n, input logic [7:0] ep);
    #1;
    `CHK("pin_o", eo, pin_o)
    `CHK("oe_n", eo_n, oe_n)
    `CHK("pullup", ep, pull)
    `CHK("periph_in", pin_w, pin_in)
    @(posedge clk);
  endtask : pins
  // Monitor: each read data phase takes the oldest note
  always @(posedge clk) begin
    if (hready === 1'b1) begin
      if (rd_dp) begin
        mv = (q.size() > 0) ? q.pop_front() : 8'hxx;
        `CHK("hrdata", {24'h0, mv}, hrdata)
        `CHK("hresp", 1'b0, hresp)
      end
      rd_dp <= hsel & (htrans == io_port_pkg::HTRANS_NONSEQ) & !hwrite;
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int r = 0; r < 2; r++) begin
      bus(1'b0, io_port_pkg::ADDR_LATCH, 8'h00, 8'hff);
      bus(1'b0, io_port_pkg::ADDR_PULLUP, 8'h00, 8'h00);
      bus(1'b0, io_port_pkg::ADDR_DRIVE, 8'h00, 8'h00);
      pins(8'hff, 8'hff, 8'h00);
      bus(1'b1, 10'h3fc, 8'h55, 8'h00);
      bus(1'b0, 10'h3fc, 8'h00, 8'h00);
      for (int i = 0; i < 6 && r == 0; i++) begin
        la = rnd();
        dr = rnd();
        pu = rnd();
        bus(1'b1, io_port_pkg::ADDR_LATCH, la, 8'h00);
        bus(1'b1, io_port_pkg::ADDR_DRIVE, dr, 8'h00);
        bus(1'b1, io_port_pkg::ADDR_PULLUP, pu, 8'h00);
        bus(1'b0, io_port_pkg::ADDR_DRIVE, 8'h00, dr);
        bus(1'b0, io_port_pkg::ADDR_PULLUP, 8'h00, pu);
        eoe = la & ~dr;
        pins(la, eoe, pu);
        ext_en <= 8'hff;
        ext <= rnd();
        bus(1'b1, io_port_pkg::ADDR_PIN, ~ext, 8'h00);
        bus(1'b0, io_port_pkg::ADDR_PIN, 8'h00, (eoe & ext) | (~eoe & la));
        bus(1'b0, io_port_pkg::ADDR_LATCH, 8'h00, la);
      end
      if (r == 0) begin
        bus(1'b1, io_port_pkg::ADDR_DRIVE, 8'hff, 8'h00);
        po = rnd();
        p_en <= 8'hff;
        p_out <= po;
        pins(la & po, 8'h00, pu);
        bus(1'b1, io_port_pkg::ADDR_LATCH, 8'hff, 8'h00);
        pins(po, 8'h00, pu);
        bus(1'b1, io_port_pkg::ADDR_DRIVE, 8'h00, 8'h00);
        prog <= 1'b1;
        for (int t = 0; t < 4; t++) begin
          tx <= t[0];
          ext <= {6'h0, t[1], 1'b0};
          @(posedge clk);
          #1;
          `CHK("tx_pin", t[0], pin_o[0])
          `CHK("boot_rx", t[1], boot)
        end
        rst <= 1'b1;
        p_en <= 8'h00;
        prog <= 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
      end
    end
    repeat (2) @(posedge clk);
    `CHK("reads_left", 0, q.size())
    report_and_stop();
  end
endmodule : eight_bit_io_port_high_current_tb_top
`undef CHK
`default_nettype wire
